// file: rtl/afm_monitor.sv
// amplifier fault monitor: sensor filtering, protection latches, query and error dispatch
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps

// Behaviour
// - all-zero or all-one hall code on a 120 degree axis flags a hall fault
// - fault query takes selector zero to three and returns eight status bits
// - selector zero: supply, current, temperature; selector one: hall fault per axis
// - selector two: continuous limit per axis; selector three: lockout triggered
// - reading the query changes no fault state and raises no error
// - on a fault with thread zero running and routine present, dispatch routine
// - disable above 92 volts, re-enable below 90 volts, shown in bit 1
// - over-voltage disables only momentarily and never dispatches the routine
// - hall fault bit set per axis while invalid; raw hall levels readable
// - hall fault disables axis when off-on-error set, and dispatches routine
// - disable below 12 volts, resume above it, shown in bit 3
// - under-voltage present at power-up triggers the routine when it exists
// - pair over 20 amps latches off until cleared plus servo-here or reset
// - over-current shuts down regardless of settings; bit 0 set
// - over 100 degrees: shut down, bit 2, dispatch; re-enable once cooler
// - lockout: hardware shutdown, motor-off state, selector three reads 3, dispatch
// - lockout recovery needs motor-off then servo-here, or reset
module afm_monitor
	import afm_pkg::*;
(
	// clock and reset
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_b_i,
	// register port
	input  wire afm_pkg::afm_bus_s          bus_i,
	output logic [afm_pkg::DW-1:0]          rdata_o,
	// power stage sensors
	input  wire afm_pkg::afm_sense_s        sense_i,
	// program executor
	input  wire logic                       thread0_run_i,
	input  wire logic                       err_label_i,
	input  wire logic                       err_ack_i,
	output logic                            err_req_o,
	// power stage control
	output logic [afm_pkg::AXES-1:0]        amp_en_o,
	output logic                            motor_off_o,
	output logic                            irq_o
);
	import afm_pkg::*;

	function automatic logic hall_bad(input logic [HALLW-1:0] code, input logic c120);
		hall_bad = c120 && (code == HALL_ALL_ZERO || code == HALL_ALL_ONE);
	endfunction

	function automatic logic [DW-1:0] zext8(input logic [7:0] v);
		zext8 = {{(DW-8){1'b0}}, v};
	endfunction

	logic [SENSEW-1:0]  sync1;
	logic [SENSEW-1:0]  sync2;
	logic [SENSEW-1:0]  sync3;
	logic [SENSEW-1:0]  filt_raw;
	afm_sense_s         filt;
	logic [AXES-1:0]    oe_on;
	logic [AXES-1:0]    c120;
	logic               ov_flag;
	logic [PAIRS-1:0]   oc_latch;
	afm_lock_e          lock_state;
	logic [AXES-1:0]    hall_fault;
	logic [EVW-1:0]     fault_now;
	logic [EVW-1:0]     fault_prev;
	logic [EVW-1:0]     rise;
	logic [EVW-1:0]     irq_stat;
	logic [EVW-1:0]     irq_en;
	logic               err_pend;
	logic               wr_cmd;
	logic               servo_here;
	logic               motor_off_cmd;
	logic               wr_clr;
	logic               dispatch_ev;
	logic               global_off;
	logic [7:0]         q0;
	logic [7:0]         q1;
	logic [7:0]         q2;
	logic [7:0]         q3;
	logic [DW-1:0]      next_rdata;

	// pins pass three flops; a change is taken only when stages two and three agree
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
		end else begin
			sync1 <= sense_i;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			filt_raw <= '0;
		end else begin
			for (int i = 0; i < SENSEW; i++) begin
				if (sync2[i] == sync3[i]) begin
					filt_raw[i] <= sync3[i];
				end
			end
		end
	end

	assign filt = afm_sense_s'(filt_raw);

	assign wr_cmd        = bus_i.wr && bus_i.addr == REG_CMD;
	assign servo_here    = wr_cmd && bus_i.wdata[CMD_SERVO_HERE];
	assign motor_off_cmd = wr_cmd && bus_i.wdata[CMD_MOTOR_OFF];
	assign wr_clr        = bus_i.wr && bus_i.addr == REG_IRQ_CLR;

	// control register
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oe_on <= CTRL_OE_RST;
			c120  <= CTRL_C120_RST;
		end else if (bus_i.wr && bus_i.addr == REG_CTRL) begin
			oe_on <= bus_i.wdata[CTRL_OE_LSB +: AXES];
			c120  <= bus_i.wdata[CTRL_C120_LSB +: AXES];
		end
	end

	always_comb begin
		for (int a = 0; a < AXES; a++) begin
			hall_fault[a] = hall_bad(filt.hall[a], c120[a]);
		end
	end

	// over-voltage hysteresis: trip above the high comparator, release below the low one
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ov_flag <= 1'b0;
		end else if (filt.above_ov_trip) begin
			ov_flag <= 1'b1;
		end else if (filt.below_ov_rel) begin
			ov_flag <= 1'b0;
		end
	end

	// over-current latch per axis pair; live over-current keeps it set
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			oc_latch <= '0;
		end else begin
			for (int p = 0; p < PAIRS; p++) begin
				if (filt.pair_over_cur[p]) begin
					oc_latch[p] <= 1'b1;
				end else if (servo_here) begin
					oc_latch[p] <= 1'b0;
				end
			end
		end
	end

	// lockout recovery: motor-off arms, servo-here then releases
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			lock_state <= LOCK_IDLE;
		end else begin
			case (lock_state)
				LOCK_IDLE: begin
					if (filt.lockout) begin
						lock_state <= LOCK_HELD;
					end
				end
				LOCK_HELD: begin
					if (motor_off_cmd && !filt.lockout) begin
						lock_state <= LOCK_ARMED;
					end
				end
				LOCK_ARMED: begin
					if (filt.lockout) begin
						lock_state <= LOCK_HELD;
					end else if (servo_here) begin
						lock_state <= LOCK_IDLE;
					end
				end
				default: begin
					lock_state <= LOCK_HELD;
				end
			endcase
		end
	end

	// under-voltage and temperature drop out as soon as their comparators do; over-voltage holds until below_ov_rel
	assign global_off = ov_flag || filt.under_volt || filt.over_temp
		|| (lock_state != LOCK_IDLE);

	always_comb begin
		for (int a = 0; a < AXES; a++) begin
			amp_en_o[a] = !global_off && !oc_latch[a / 2]
				&& !(hall_fault[a] && oe_on[a]);
		end
	end

	assign motor_off_o = lock_state != LOCK_IDLE;

	assign fault_now[EV_OC]   = |oc_latch;
	assign fault_now[EV_OV]   = ov_flag;
	assign fault_now[EV_OT]   = filt.over_temp;
	assign fault_now[EV_UV]   = filt.under_volt;
	assign fault_now[EV_HALL] = |hall_fault;
	assign fault_now[EV_LOCKOUT] = lock_state != LOCK_IDLE;
	assign fault_now[EV_CONT] = |filt.over_cont;

	// prev starts clear so a supply missing at power-up still counts as a new fault
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fault_prev <= '0;
		end else begin
			fault_prev <= fault_now;
		end
	end

	assign rise = fault_now & ~fault_prev;
	// over-voltage and the continuous-limit monitor never start the routine
	assign dispatch_ev = rise[EV_OC] || rise[EV_OT] || rise[EV_UV]
		|| rise[EV_HALL] || rise[EV_LOCKOUT];

	// routine request waits for thread zero; a new fault wins over the acknowledge
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			err_pend <= 1'b0;
		end else if (dispatch_ev && err_label_i) begin
			err_pend <= 1'b1;
		end else if (err_ack_i || !err_label_i) begin
			err_pend <= 1'b0;
		end
	end

	assign err_req_o = err_pend && thread0_run_i && err_label_i;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_en <= '0;
		end else if (bus_i.wr && bus_i.addr == REG_IRQ_EN) begin
			irq_en <= bus_i.wdata[EVW-1:0];
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~(wr_clr ? bus_i.wdata[EVW-1:0] : '0)) | rise;
		end
	end

	assign irq_o = |(irq_stat & irq_en);

	// query words are pure views of the live state
	always_comb begin
		q0 = '0;
		q0[Q0_OVER_CURRENT] = |oc_latch;
		q0[Q0_OVER_VOLTAGE] = ov_flag;
		q0[Q0_OVER_TEMP]    = filt.over_temp;
		q0[Q0_UNDER_VOLT]   = filt.under_volt;
		q1 = {4'h0, hall_fault};
		q2 = {4'h0, filt.over_cont};
		q3 = (lock_state != LOCK_IDLE) ? LOCKOUT_CODE : 8'h00;
	end

	always_comb begin
		next_rdata = '0;
		if (bus_i.rd) begin
			case (bus_i.addr)
				REG_CTRL:     next_rdata = zext8({c120, oe_on});
				REG_QUERY0:   next_rdata = zext8(q0);
				REG_QUERY1:   next_rdata = zext8(q1);
				REG_QUERY2:   next_rdata = zext8(q2);
				REG_QUERY3:   next_rdata = zext8(q3);
				REG_HALL:     next_rdata = {{(DW-AXES*HALLW){1'b0}}, filt.hall};
				REG_IRQ_STAT: next_rdata = zext8({1'b0, irq_stat});
				REG_IRQ_EN:   next_rdata = zext8({1'b0, irq_en});
				REG_AMP:      next_rdata = zext8({3'h0, motor_off_o, amp_en_o});
				default:      next_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= '0;
		end else begin
			rdata_o <= next_rdata;
		end
	end

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_b_i);

	hall_flag_a: assert property (filt.hall[2] == HALL_ALL_ONE && c120[2] |-> q1[2])
		else $error("hall all-one code not flagged");
	query_hall_a: assert property (bus_i.rd && bus_i.addr == REG_QUERY1
		|=> rdata_o[3:0] == $past(q1[3:0]))
		else $error("selector one read wrong");
	query_pure_a: assert property (bus_i.rd && !bus_i.wr
		|=> irq_stat == ($past(irq_stat) | $past(rise)))
		else $error("query read changed status");
	ov_release_a: assert property (ov_flag && !filt.above_ov_trip && !filt.below_ov_rel
		|=> ov_flag)
		else $error("over-voltage released inside hysteresis");
	// a lone over-voltage rise must leave the routine request idle
	ov_no_dispatch_a: assert property (rise == (EVW'(1) << EV_OV) && !err_pend
		|=> !err_pend)
		else $error("over-voltage dispatched routine");
	uv_disable_a: assert property (filt.under_volt |-> amp_en_o == '0)
		else $error("amplifier on under low supply");
	oc_hold_a: assert property (oc_latch[0] && !servo_here
		|=> oc_latch[0] && !amp_en_o[1])
		else $error("over-current latch released early");
	lock_hold_a: assert property (lock_state == LOCK_HELD && !motor_off_cmd
		|=> lock_state == LOCK_HELD)
		else $error("lockout released without motor-off");
	lock_query_a: assert property (motor_off_o |-> q3 == LOCKOUT_CODE && amp_en_o == '0)
		else $error("lockout not shown or not shut down");
	dispatch_a: assert property (dispatch_ev && err_label_i && thread0_run_i
		|=> err_req_o)
		else $error("routine not requested");

	lock_recover_c: cover property (lock_state == LOCK_ARMED ##[1:20] lock_state == LOCK_IDLE);
	oc_recover_c: cover property (oc_latch[0] ##[1:50] !oc_latch[0]);
	no_label_c: cover property (dispatch_ev && !err_label_i);
	hall_dispatch_c: cover property (rise[EV_HALL] ##1 err_req_o);
	irq_c: cover property ($rose(irq_o));
endmodule

// file: rtl/afm_pkg.sv
// shared constants and carriers for the amplifier fault monitor
package afm_pkg;
	localparam int AXES  = 4;
	localparam int PAIRS = 2;
	localparam int HALLW = 3;
	localparam int AW    = 8;
	localparam int DW    = 32;

	// register byte offsets
	localparam logic [AW-1:0] REG_CTRL     = 8'h00;
	localparam logic [AW-1:0] REG_CMD      = 8'h04;
	localparam logic [AW-1:0] REG_QUERY0   = 8'h08;
	localparam logic [AW-1:0] REG_QUERY1   = 8'h0c;
	localparam logic [AW-1:0] REG_QUERY2   = 8'h10;
	localparam logic [AW-1:0] REG_QUERY3   = 8'h14;
	localparam logic [AW-1:0] REG_HALL     = 8'h18;
	localparam logic [AW-1:0] REG_IRQ_STAT = 8'h1c;
	localparam logic [AW-1:0] REG_IRQ_EN   = 8'h20;
	localparam logic [AW-1:0] REG_IRQ_CLR  = 8'h24;
	localparam logic [AW-1:0] REG_AMP      = 8'h28;

	// control register fields
	localparam int CTRL_OE_LSB   = 0;
	localparam int CTRL_C120_LSB = 4;
	localparam logic [AXES-1:0] CTRL_OE_RST   = 4'h0;
	localparam logic [AXES-1:0] CTRL_C120_RST = 4'hf;

	// command register bits
	localparam int CMD_SERVO_HERE = 0;
	localparam int CMD_MOTOR_OFF  = 1;

	// selector-zero status bits
	localparam int Q0_OVER_CURRENT = 0;
	localparam int Q0_OVER_VOLTAGE = 1;
	localparam int Q0_OVER_TEMP    = 2;
	localparam int Q0_UNDER_VOLT   = 3;
	localparam logic [7:0] LOCKOUT_CODE = 8'h03;

	// interrupt event bits
	localparam int EV_OC   = 0;
	localparam int EV_OV   = 1;
	localparam int EV_OT   = 2;
	localparam int EV_UV   = 3;
	localparam int EV_HALL = 4;
	localparam int EV_LOCKOUT = 5;
	localparam int EV_CONT = 6;
	localparam int EVW     = 7;

	localparam logic [HALLW-1:0] HALL_ALL_ZERO = 3'h0;
	localparam logic [HALLW-1:0] HALL_ALL_ONE  = 3'h7;

	typedef struct packed {
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic          wr;
		logic          rd;
	} afm_bus_s;

	// comparator levels from the power stage, all active high
	typedef struct packed {
		logic [AXES-1:0][HALLW-1:0] hall;
		logic                       under_volt;
		logic                       above_ov_trip;
		logic                       below_ov_rel;
		logic [PAIRS-1:0]           pair_over_cur;
		logic                       over_temp;
		logic [AXES-1:0]            over_cont;
		logic                       lockout;
	} afm_sense_s;

	localparam int SENSEW = $bits(afm_sense_s);

	typedef enum logic [1:0] {
		LOCK_IDLE,
		LOCK_HELD,
		LOCK_ARMED
	} afm_lock_e;
endpackage

// file: tb/afm_stage_model.sv
// power stage comparators and program executor stand-in
`timescale 1ns/10ps
module afm_stage_model
	import afm_pkg::*;
(
	// clock and reset
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_b_i,
	// analogue levels in volts, amps, degrees
	input  var  int                         supply_v_i,
	input  var  int                         temp_c_i,
	input  var  int                         cur_a_i,
	input  var  int                         cur_b_i,
	input  wire logic [AXES-1:0][HALLW-1:0] hall_i,
	input  wire logic [AXES-1:0]            over_cont_i,
	input  wire logic                       lockout_i,
	// executor side
	input  wire logic                       err_req_i,
	output logic                            err_ack_o,
	output int                              ack_cnt_o,
	output afm_pkg::afm_sense_s             sense_o
);
	import afm_pkg::*;
	logic [1:0] dly;
	assign sense_o.hall          = hall_i;
	assign sense_o.under_volt    = supply_v_i < 12;
	assign sense_o.above_ov_trip = supply_v_i > 92;
	assign sense_o.below_ov_rel  = supply_v_i < 90;
	assign sense_o.pair_over_cur = {cur_b_i > 20, cur_a_i > 20};
	assign sense_o.over_temp     = temp_c_i > 100;
	assign sense_o.over_cont     = over_cont_i;
	assign sense_o.lockout       = lockout_i;
	// executor answers two cycles late, like a busy program
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dly <= 2'h0;
			err_ack_o <= 1'b0;
			ack_cnt_o <= 0;
		end else begin
			err_ack_o <= 1'b0;
			dly <= (err_req_i && !err_ack_o) ? dly + 2'h1 : 2'h0;
			if (dly == 2'h1 && err_req_i) begin
				err_ack_o <= 1'b1;
				ack_cnt_o <= ack_cnt_o + 1;
				dly <= 2'h0;
			end
		end
	end
endmodule

// file: tb/amp_fault_monitor_test.sv
// bus-level tests of the amplifier fault monitor
`timescale 1ns/10ps
module amp_fault_monitor_test;
	import afm_pkg::*;
	logic                       core_clk_i;
	logic                       rst_b_i;
	afm_bus_s                   bus;
	logic [DW-1:0]              rdata_o;
	afm_sense_s                 sense;
	logic                       err_req_o;
	logic                       err_ack;
	logic [AXES-1:0]            amp_en_o;
	logic                       motor_off_o;
	logic                       irq_o;
	int                         supply_v;
	int                         temp_c;
	int                         cur_a;
	int                         cur_b;
	int                         acks;
	int                         a0;
	logic [AXES-1:0][HALLW-1:0] hall;
	logic [AXES-1:0]            over_cont;
	logic                       lockout;
	logic                       thread0_run;
	logic                       err_label;
	int                         err_count;
	int                         checks;

	afm_monitor afm_monitor_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_i(bus),
		.rdata_o(rdata_o), .sense_i(sense), .thread0_run_i(thread0_run),
		.err_label_i(err_label),
		.err_ack_i(err_ack), .err_req_o(err_req_o), .amp_en_o(amp_en_o),
		.motor_off_o(motor_off_o), .irq_o(irq_o));
	afm_stage_model afm_stage_model_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
		.supply_v_i(supply_v), .temp_c_i(temp_c), .cur_a_i(cur_a), .cur_b_i(cur_b),
		.hall_i(hall), .over_cont_i(over_cont), .lockout_i(lockout),
		.err_req_i(err_req_o), .err_ack_o(err_ack), .ack_cnt_o(acks), .sense_o(sense));

	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end

	task check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge core_clk_i);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge core_clk_i);
		bus.wr <= 1'b0;
	endtask
	task rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
		@(posedge core_clk_i);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge core_clk_i);
		bus.rd <= 1'b0;
		#1 check(rdata_o, e);
	endtask
	// sensor pins need four edges of filtering, plus executor latency
	task settle();
		repeat (12) @(posedge core_clk_i);
	endtask
	task done(input string name);
		$display("test %s finished", name);
		a0 = acks;
	endtask
	task summarize();
		$display("checks %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		#50us;
		err_count++;
		summarize();
	end

	initial begin
		err_count = 0;
		checks = 0;
		bus = '0;
		rst_b_i = 1'b0;
		supply_v = 0;
		temp_c = 25;
		cur_a = 0;
		cur_b = 0;
		hall = {4{3'h1}};
		over_cont = 4'h0;
		lockout = 1'b0;
		thread0_run = 1'b1;
		err_label = 1'b1;
		repeat (5) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		settle();
		check(32'(acks != 0), 32'h1);
		rd(REG_QUERY0, 32'h08);
		rd(REG_AMP, 32'h00);
		rd(REG_CTRL, 32'hf0);
		rd(8'h3c, 32'h0);
		@(posedge core_clk_i) supply_v <= 48;
		settle();
		rd(REG_QUERY0, 32'h00);
		rd(REG_AMP, 32'h0f);
		done("supply");
		@(posedge core_clk_i) hall <= {3'h1, 3'h7, 3'h0, 3'h1};
		settle();
		rd(REG_QUERY1, 32'h06);
		rd(REG_HALL, 32'h3c1);
		rd(REG_AMP, 32'h0f);
		wr(REG_CTRL, 32'hff);
		rd(REG_AMP, 32'h09);
		rd(REG_QUERY1, 32'h06);
		check(32'(acks - a0), 32'h1);
		@(posedge core_clk_i) hall <= {4{3'h1}};
		wr(REG_CTRL, 32'hf0);
		settle();
		done("hall");
		@(posedge core_clk_i) supply_v <= 95;
		settle();
		rd(REG_QUERY0, 32'h02);
		rd(REG_AMP, 32'h00);
		@(posedge core_clk_i) supply_v <= 91;
		settle();
		rd(REG_QUERY0, 32'h02);
		@(posedge core_clk_i) supply_v <= 85;
		settle();
		rd(REG_AMP, 32'h0f);
		check(32'(acks - a0), 32'h0);
		done("overvoltage");
		@(posedge core_clk_i) cur_a <= 25;
		settle();
		rd(REG_QUERY0, 32'h01);
		rd(REG_AMP, 32'h0c);
		wr(REG_CMD, 32'h1);
		rd(REG_AMP, 32'h0c);
		@(posedge core_clk_i) cur_a <= 10;
		settle();
		rd(REG_AMP, 32'h0c);
		wr(REG_CMD, 32'h1);
		rd(REG_AMP, 32'h0f);
		done("overcurrent");
		wr(REG_IRQ_CLR, 32'h7f);
		wr(REG_IRQ_EN, 32'h04);
		@(posedge core_clk_i) temp_c <= 105;
		settle();
		rd(REG_QUERY0, 32'h04);
		rd(REG_AMP, 32'h00);
		check(32'(acks - a0), 32'h1);
		check(32'(irq_o), 32'h1);
		rd(REG_IRQ_STAT, 32'h04);
		@(posedge core_clk_i) temp_c <= 95;
		settle();
		rd(REG_QUERY0, 32'h00);
		check(32'(irq_o), 32'h1);
		wr(REG_IRQ_CLR, 32'h04);
		#1 check(32'(irq_o), 32'h0);
		done("temperature");
		// no routine in the program: a fault must not be dispatched
		err_label <= 1'b0;
		@(posedge core_clk_i) temp_c <= 105;
		settle();
		check(32'(acks - a0), 32'h0);
		@(posedge core_clk_i) temp_c <= 95;
		settle();
		// routine present but thread zero idle: request waits for it
		err_label <= 1'b1;
		thread0_run <= 1'b0;
		@(posedge core_clk_i) temp_c <= 105;
		settle();
		check(32'(err_req_o), 32'h0);
		thread0_run <= 1'b1;
		settle();
		check(32'(acks - a0), 32'h1);
		@(posedge core_clk_i) temp_c <= 95;
		settle();
		done("dispatch");
		@(posedge core_clk_i) over_cont <= 4'h8;
		settle();
		rd(REG_QUERY2, 32'h08);
		wr(REG_CTRL, 32'hff);
		rd(REG_AMP, 32'h0f);
		@(posedge core_clk_i) lockout <= 1'b1;
		settle();
		rd(REG_QUERY3, 32'h03);
		rd(REG_AMP, 32'h10);
		check(32'(acks - a0), 32'h1);
		@(posedge core_clk_i) lockout <= 1'b0;
		settle();
		wr(REG_CMD, 32'h1);
		rd(REG_QUERY3, 32'h03);
		wr(REG_CMD, 32'h2);
		wr(REG_CMD, 32'h1);
		rd(REG_QUERY3, 32'h00);
		rd(REG_AMP, 32'h0f);
		done("lockout");
		// a controller reset also ends a lockout
		@(posedge core_clk_i) lockout <= 1'b1;
		settle();
		check(32'(motor_off_o), 32'h1);
		rst_b_i <= 1'b0;
		repeat (5) @(posedge core_clk_i);
		check(32'(motor_off_o), 32'h0);
		lockout <= 1'b0;
		rst_b_i <= 1'b1;
		settle();
		rd(REG_QUERY3, 32'h00);
		rd(REG_AMP, 32'h0f);
		done("reset");
		summarize();
	end
endmodule
